// [rtl/trigger_event_routing.sv]
// trigger acceptance, pause and data latency, event export routing
// Behaviour
// - in acquisition, after a start trigger a reference trigger is accepted after the start rearm count of samples, at most 64.
// - between two reference triggers the rearm count is the reference rearm count, at most 153 samples.
// - start may be exported to any function or backplane line, reference and advance only in acquisition.
// - the pause trigger is never driven onto any line and such a route is refused.
// - in generation the paused state follows the pause trigger by 32 sample periods plus 150 ns.
// - in acquisition the pause applies on the next sample with no fixed offset.
// - accepted triggers and data reach the outputs 32 sample periods plus 160 ns later.
// - markers 0 to 3 and data-active exist only in generation, ready-for-start in both sessions.
// - ready-for-advance exists only in acquisition.
// - end-of-record exists only in acquisition and pulses when a record completes.
// - every event except data-active may go to any function or backplane line.
// - data-active may go only to function lines, backplane routes are refused.
// - pause is level detected with selectable active level.
// - start is edge detected on a selectable edge.
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module trigger_event_routing import trig_pkg::*; #(
   parameter int DW = `DATA_CHANNELS,
   parameter int NFUNC = `NUM_FUNC_LINES,
   parameter int NBP = `NUM_BP_LINES,
   parameter int START_REARM = `START_REARM_TYP_S,
   parameter int REF_REARM = `REF_REARM_TYP_S
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // sample timing and configuration
   input wire logic sample_en_i,
   input wire cfg_t cfg_i,
   input wire logic stop_i,
   input wire src_t [NFUNC+NBP-1:0] route_sel_i,
   // trigger inputs
   input wire logic start_i,
   input wire logic ref_i,
   input wire logic adv_i,
   input wire logic pause_i,
   // pattern engine
   input wire logic [DW-1:0] data_i,
   input wire logic [`NUM_MARKERS-1:0] marker_i,
   input wire logic record_done_i,
   // exported lines, function lines first then backplane
   output logic [NFUNC+NBP-1:0] line_o,
   output logic [NFUNC+NBP-1:0] line_oe_o,
   output logic [NFUNC+NBP-1:0] route_err_o,
   // status and data
   output evt_t ev_o,
   output logic paused_o,
   output logic start_acc_o,
   output logic ref_acc_o,
   output logic [DW-1:0] data_o,
   output logic trig_o
);
   localparam int ND = NFUNC + NBP;
   localparam int PFIX = `PAUSE_FIX_CYC;
   localparam int DFIX = `DATA_FIX_CYC;
   localparam int RW = `REARM_W;

   if (START_REARM < 1 || START_REARM > `START_REARM_MAX_S ||
       REF_REARM < 1 || REF_REARM > `REF_REARM_MAX_S ||
       NFUNC < 1 || NBP < 1 || DW < 1 || PFIX < 2) begin : g_chk
      $error("trigger_event_routing parameters out of range");
   end

   typedef struct packed {
      phase_t phase;
      logic start_d;
      logic ref_d;
      logic adv_d;
      logic [RW-1:0] rearm;
      logic [PFIX-1:0] pause_sh;
      logic pause_eff;
      logic start_acc;
      logic ref_acc;
      logic trig_hold;
      logic paused;
      evt_t ev;
      logic [ND-1:0] line;
      logic [ND-1:0] oe;
      logic [ND-1:0] err;
   } state_t;

   state_t r;
   state_t s;
   logic pause_act;
   logic start_edge;
   logic ref_edge;
   logic adv_edge;
   logic [DW+1:0] smp_q;
   logic [DW:0] fix_q;
   logic smp_pause;

   function automatic logic route_ok(src_t src, logic bp, logic gen);
      logic ok;
      ok = 1'b0;
      case (src)
         SRC_NONE: ok = 1'b0;
         SRC_PAUSE: ok = 1'b0;
         SRC_DACT: ok = gen & ~bp;
         SRC_MARK0, SRC_MARK1, SRC_MARK2, SRC_MARK3: ok = gen;
         SRC_REF, SRC_ADV, SRC_RDY_ADV, SRC_EOR: ok = ~gen;
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction

   function automatic logic src_level(src_t src, evt_t e, logic st,
                                      logic rf, logic ad);
      logic v;
      v = 1'b0;
      case (src)
         SRC_START: v = st;
         SRC_REF: v = rf;
         SRC_ADV: v = ad;
         SRC_MARK0: v = e.marker[0];
         SRC_MARK1: v = e.marker[1];
         SRC_MARK2: v = e.marker[2];
         SRC_MARK3: v = e.marker[3];
         SRC_DACT: v = e.data_active;
         SRC_RDY_START: v = e.ready_start;
         SRC_RDY_ADV: v = e.ready_adv;
         SRC_EOR: v = e.end_record;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   assign pause_act = pause_i ^ cfg_i.pause_low;
   assign start_edge = cfg_i.start_fall ? (r.start_d & ~start_i) :
                       (~r.start_d & start_i);
   assign ref_edge = ref_i & ~r.ref_d;
   assign adv_edge = adv_i & ~r.adv_d;

   // sample-clock part of the trigger-to-output and pause latency
   delay_line #(.W(DW + 2), .D(`SMP_LAT_S)) u_smp (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(sample_en_i),
      .d_i({data_i, r.trig_hold | r.start_acc | r.ref_acc, pause_act}),
      .q_o(smp_q)
   );
   assign smp_pause = smp_q[0];

   // fixed-time part of the data latency, counted in mclk cycles
   delay_line #(.W(DW + 1), .D(DFIX)) u_fix (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(1'b1),
      .d_i(smp_q[DW+1:1]),
      .q_o(fix_q)
   );

   always_comb begin
      s = r;
      s.start_d = start_i;
      s.ref_d = ref_i;
      s.adv_d = adv_i;
      s.start_acc = 1'b0;
      s.ref_acc = 1'b0;
      s.pause_sh = {r.pause_sh[PFIX-2:0], smp_pause};
      // accept pulse is one mclk wide, held so a slow sample cannot miss it
      s.trig_hold = sample_en_i ? 1'b0 :
                    (r.trig_hold | r.start_acc | r.ref_acc);
      // registered a cycle late so it lines up with the event levels
      s.paused = r.phase == PH_PAUSE;
      // acquisition pause lands with the sample, no fixed offset
      s.pause_eff = cfg_i.gen_mode ? r.pause_sh[PFIX-1] :
                    (sample_en_i ? pause_act : r.pause_eff);
      if (sample_en_i && r.rearm != '0) begin
         s.rearm = r.rearm - RW'(1);
      end
      case (r.phase)
         PH_IDLE: begin
            if (start_edge) begin
               s.start_acc = 1'b1;
               s.rearm = RW'(START_REARM);
               s.phase = PH_RUN;
            end
         end
         PH_RUN: begin
            if (stop_i) begin
               s.phase = PH_IDLE;
            end else if (r.pause_eff) begin
               s.phase = PH_PAUSE;
            end
         end
         PH_PAUSE: begin
            if (stop_i) begin
               s.phase = PH_IDLE;
            end else if (!r.pause_eff) begin
               s.phase = PH_RUN;
            end
         end
         default: s.phase = PH_IDLE;
      endcase
      // early reference edges are simply dropped
      if (r.phase != PH_IDLE && !cfg_i.gen_mode && ref_edge &&
          r.rearm == '0) begin
         s.ref_acc = 1'b1;
         s.rearm = RW'(REF_REARM);
      end
      s.ev.marker = (cfg_i.gen_mode && r.phase == PH_RUN) ?
                    marker_i : '0;
      s.ev.data_active = cfg_i.gen_mode && r.phase == PH_RUN;
      s.ev.ready_start = r.phase == PH_IDLE;
      s.ev.ready_adv = !cfg_i.gen_mode && r.phase != PH_IDLE &&
                       r.rearm == '0;
      s.ev.end_record = !cfg_i.gen_mode && r.phase != PH_IDLE &&
                        record_done_i;
      for (int d = 0; d < ND; d++) begin
         s.oe[d] = route_ok(route_sel_i[d], d >= NFUNC, cfg_i.gen_mode);
         s.err[d] = route_sel_i[d] != SRC_NONE && !s.oe[d];
         s.line[d] = s.oe[d] && src_level(route_sel_i[d], r.ev,
                     r.start_acc, r.ref_acc, adv_edge);
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
         r.phase <= PH_IDLE;
      end else begin
         r <= s;
      end
   end

   assign line_o = r.line;
   assign line_oe_o = r.oe;
   assign route_err_o = r.err;
   assign ev_o = r.ev;
   assign paused_o = r.paused;
   assign start_acc_o = r.start_acc;
   assign ref_acc_o = r.ref_acc;
   assign data_o = fix_q[DW:1];
   assign trig_o = fix_q[0];

   // checking helpers
   logic [ND-1:0] sel_pause;
   logic [ND-1:0] sel_dact_bp;
   always_comb begin
      for (int d = 0; d < ND; d++) begin
         sel_pause[d] = route_sel_i[d] == SRC_PAUSE;
         sel_dact_bp[d] = route_sel_i[d] == SRC_DACT && d >= NFUNC;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   property p_start_rearm;
      r.start_acc |-> r.rearm == RW'(START_REARM) && !r.ref_acc;
   endproperty
   a_start_rearm: assert property (p_start_rearm)
      else $error("start did not load start rearm");
   property p_ref_rearm;
      r.ref_acc |-> r.rearm == RW'(REF_REARM) && $past(r.rearm) == '0;
   endproperty
   a_ref_rearm: assert property (p_ref_rearm)
      else $error("reference accepted inside rearm");
   property p_ref_ignore;
      (ref_edge && r.rearm != '0) |=> !r.ref_acc;
   endproperty
   a_ref_ignore: assert property (p_ref_ignore)
      else $error("early reference not ignored");
   property p_no_pause_out;
      ##1 (($past(sel_pause) & r.oe) == '0) &&
          ((r.err & $past(sel_pause)) == $past(sel_pause));
   endproperty
   a_no_pause_out: assert property (p_no_pause_out)
      else $error("pause driven or not flagged");
   property p_dact_bp;
      ##1 ($past(sel_dact_bp) & (r.oe | ~r.err)) == '0;
   endproperty
   a_dact_bp: assert property (p_dact_bp)
      else $error("data active on backplane");
   property p_pause_gen;
      (cfg_i.gen_mode && $past(cfg_i.gen_mode) && $rose(r.pause_eff)) |->
         $past(smp_pause, PFIX + 1) && !$past(smp_pause, PFIX + 2);
   endproperty
   a_pause_gen: assert property (p_pause_gen)
      else $error("generation pause latency wrong");
   property p_pause_acq;
      (!cfg_i.gen_mode && sample_en_i) |=> r.pause_eff == $past(pause_act);
   endproperty
   a_pause_acq: assert property (p_pause_acq)
      else $error("acquisition pause not sample aligned");
   property p_data_lat;
      trig_o |-> $past(smp_q[1], DFIX);
   endproperty
   a_data_lat: assert property (p_data_lat)
      else $error("trigger output latency wrong");
   property p_gen_only;
      !cfg_i.gen_mode |=> r.ev.marker == '0 && !r.ev.data_active;
   endproperty
   a_gen_only: assert property (p_gen_only)
      else $error("generation event in acquisition");
   property p_acq_only;
      cfg_i.gen_mode |=> !r.ev.ready_adv && !r.ev.end_record;
   endproperty
   a_acq_only: assert property (p_acq_only)
      else $error("acquisition event in generation");
   property p_start_edge;
      r.start_acc |-> $past(start_i) != $past(r.start_d);
   endproperty
   a_start_edge: assert property (p_start_edge)
      else $error("start taken without edge");

   c_ref: cover property (r.start_acc ##[1:1000] r.ref_acc);
   c_gen_pause: cover property (cfg_i.gen_mode && $rose(paused_o));
   c_err: cover property (r.err != '0);
endmodule
`default_nettype wire

// [inc/trig_params.svh]
// timing and field constants for trigger and event routing
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH
`define MCLK_PERIOD_PS 5000
`define START_REARM_TYP_S 57
`define START_REARM_MAX_S 64
`define REF_REARM_TYP_S 132
`define REF_REARM_MAX_S 153
`define REARM_W 8
`define SMP_LAT_S 32
`define PAUSE_FIX_NS 150
`define DATA_FIX_NS 160
`define PAUSE_FIX_CYC ((`PAUSE_FIX_NS * 1000) / `MCLK_PERIOD_PS)
`define DATA_FIX_CYC ((`DATA_FIX_NS * 1000) / `MCLK_PERIOD_PS)
`define NUM_FUNC_LINES 4
`define NUM_BP_LINES 7
`define NUM_MARKERS 4
`define DATA_CHANNELS 32
`endif

// [inc/trig_pkg.sv]
// types shared by the trigger and event routing block
package trig_pkg;
   typedef enum logic [3:0] {
      SRC_NONE = 4'h0,
      SRC_START = 4'h1,
      SRC_REF = 4'h2,
      SRC_ADV = 4'h3,
      SRC_PAUSE = 4'h4,
      SRC_MARK0 = 4'h5,
      SRC_MARK1 = 4'h6,
      SRC_MARK2 = 4'h7,
      SRC_MARK3 = 4'h8,
      SRC_DACT = 4'h9,
      SRC_RDY_START = 4'ha,
      SRC_RDY_ADV = 4'hb,
      SRC_EOR = 4'hc
   } src_t;

   typedef enum logic [2:0] {
      PH_IDLE = 3'h1,
      PH_RUN = 3'h2,
      PH_PAUSE = 3'h4
   } phase_t;

   typedef struct packed {
      logic gen_mode;
      logic start_fall;
      logic pause_low;
   } cfg_t;

   typedef struct packed {
      logic [3:0] marker;
      logic data_active;
      logic ready_start;
      logic ready_adv;
      logic end_record;
   } evt_t;
endpackage

// [rtl/delay_line.sv]
// fixed-depth delay line, advancing on an enable
`timescale 1ns/1ps
`default_nettype none
module delay_line #(
   parameter int W = 1,
   parameter int D = 1
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // data
   input wire logic en_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
   } dl_state_t;

   dl_state_t r;
   dl_state_t s;

   if (W < 1 || D < 1) begin : g_chk
      $error("delay_line needs W and D of at least one");
   end

   always_comb begin
      s = r;
      if (en_i) begin
         s.mem[0] = d_i;
         for (int i = 1; i < D; i++) begin
            s.mem[i] = r.mem[i-1];
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= s;
      end
   end

   assign q_o = r.mem[D-1];
endmodule
`default_nettype wire

// [bench/ext_instr.sv]
// external instrument model: sample divider, trigger lines, markers
`timescale 1ns/1ps
`default_nettype none
module ext_instr #(
   parameter int DIV = 4
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // toward the block
   output logic sample_en_o,
   output logic [3:0] marker_o,
   output logic start_o,
   output logic ref_o,
   output logic pause_o,
   output logic done_o
);
   int div_r = 0;
   int smp_r = 0;
   initial begin
      sample_en_o = 1'b0;
      marker_o = '0;
      {start_o, ref_o, pause_o, done_o} = '0;
   end
   // changes land just after the edge, like every other stimulus
   always @(posedge mclk_i) begin
      #1;
      if (rst_i) begin
         div_r = 0;
         smp_r = 0;
         sample_en_o = 1'b0;
      end else begin
         sample_en_o = (div_r == DIV - 1);
         div_r = sample_en_o ? 0 : div_r + 1;
         if (sample_en_o) begin
            // markers move only on even sample positions
            if (smp_r[0] == 1'b0) marker_o = 4'($urandom);
            smp_r = smp_r + 1;
         end
      end
   end
   task automatic drive(input int which, input logic v);
      case (which)
         0: start_o = v;
         1: ref_o = v;
         2: pause_o = v;
         default: done_o = v;
      endcase
   endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for trigger and event routing
`timescale 1ns/1ps
`default_nettype none
module tb;
   import trig_pkg::*;
   localparam int DIV = 4;
   localparam int ND = 11;
   localparam int TOL = DIV + 2;
   localparam int SR = 57;
   localparam int RR = 132;
   localparam int LAT = 32 * DIV;
   typedef struct {int cyc; int kind;} note_t;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic stop_i = 1'b0;
   logic adv_i = 1'b0;
   cfg_t cfg_i = '0;
   logic [31:0] data_i = '0;
   src_t [ND-1:0] route_sel_i;
   logic sample_en_i, start_i, ref_i, pause_i, record_done_i;
   logic [3:0] marker_i;
   logic [ND-1:0] line_o, line_oe_o, route_err_o;
   evt_t ev_o;
   logic paused_o, start_acc_o, ref_acc_o, trig_o;
   // trig_o stands a whole sample period, so only its rise is a result
   logic trig_d = 1'b0;
   logic [31:0] data_o;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int t0, t1, r;
   note_t acc_q[$];
   int trig_q[$];
   note_t nt, m_nt;

   initial forever #2.5 mclk_i = ~mclk_i;

   ext_instr #(.DIV(DIV)) u_ext (.mclk_i(mclk_i), .rst_i(rst_i),
      .sample_en_o(sample_en_i), .marker_o(marker_i), .start_o(start_i),
      .ref_o(ref_i), .pause_o(pause_i), .done_o(record_done_i));

   trigger_event_routing #(.DW(32), .NFUNC(4), .NBP(7),
      .START_REARM(SR), .REF_REARM(RR)) u_dut (
      .mclk_i(mclk_i), .rst_i(rst_i), .sample_en_i(sample_en_i),
      .cfg_i(cfg_i), .stop_i(stop_i), .route_sel_i(route_sel_i),
      .start_i(start_i), .ref_i(ref_i), .adv_i(adv_i), .pause_i(pause_i),
      .data_i(data_i), .marker_i(marker_i), .record_done_i(record_done_i),
      .line_o(line_o), .line_oe_o(line_oe_o), .route_err_o(route_err_o),
      .ev_o(ev_o), .paused_o(paused_o), .start_acc_o(start_acc_o),
      .ref_acc_o(ref_acc_o), .data_o(data_o), .trig_o(trig_o));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic smp(int n);
      repeat (n) @(posedge sample_en_i);
      tick(1);
   endtask

   // {err, oe} for a source on a destination
   function automatic logic [1:0] rt_exp(logic gen, int s, int d);
      logic bad;
      bad = (s == 4) || (s == 9 && d >= 4) || (!gen && s >= 5 && s <= 9)
         || (gen && (s == 2 || s == 3 || s == 11 || s == 12));
      if (s == 0) return 2'b00;
      return bad ? 2'b10 : 2'b01;
   endfunction

   task automatic expect_acc(int kind);
      nt.cyc = cyc + 1;
      nt.kind = kind;
      acc_q.push_back(nt);
      // first sample may come up to a divider period late
      trig_q.push_back(cyc + 1 + LAT + 32 + DIV / 2);
   endtask

   task automatic do_start(logic fall);
      u_ext.drive(0, fall);
      tick(2);
      u_ext.drive(0, !fall);
      expect_acc(1);
      tick(2);
      u_ext.drive(0, 1'b0);
   endtask

   task automatic do_ref(bit ok);
      u_ext.drive(1, 1'b1);
      if (ok) expect_acc(2);
      tick(2);
      u_ext.drive(1, 1'b0);
   endtask

   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   always @(negedge mclk_i) begin
      if (!rst_i && (start_acc_o || ref_acc_o)) begin
         if (acc_q.size() == 0) chk("spurious accept", 0, 1);
         else begin
            m_nt = acc_q.pop_front();
            chk("accept kind", m_nt.kind, {ref_acc_o, start_acc_o});
            chk("accept cycle", m_nt.cyc, cyc);
         end
      end
      if (!rst_i && trig_o && !trig_d) begin
         if (trig_q.size() == 0) chk("spurious trig", 0, 1);
         else begin
            t1 = trig_q.pop_front();
            chk("trig delay", 1, cyc >= t1 - TOL && cyc <= t1 + TOL);
         end
      end
      trig_d = trig_o;
   end

   initial begin
      for (int d = 0; d < ND; d++) route_sel_i[d] = SRC_NONE;
      void'($urandom(27));
      tick(6);
      rst_i = 1'b0;
      tick(2);
      chk("ready start", 1, ev_o.ready_start);
      for (int m = 0; m < 2; m++) begin
         cfg_i.gen_mode = m[0];
         for (int s = 0; s < 13; s++) begin
            r = $urandom % 13;
            for (int d = 0; d < ND; d++) route_sel_i[d] = src_t'((s+d+r) % 13);
            tick(2);
            for (int d = 0; d < ND; d++) begin
               t1 = (s + d + r) % 13;
               chk("route", rt_exp(m[0], t1, d), {route_err_o[d], line_oe_o[d]});
               if (t1 == 10) chk("ready line", 1, line_o[d]);
            end
         end
      end
      for (int d = 0; d < ND; d++) route_sel_i[d] = SRC_NONE;
      data_i = $urandom;
      tick(LAT + 32 + 2 * DIV);
      chk("data out", data_i, data_o);
      for (int m = 0; m < 2; m++) begin
         cfg_i = '{gen_mode: m[0], start_fall: m[0], pause_low: m[0]};
         u_ext.drive(2, m[0]);
         tick(2);
         do_start(m[0]);
         tick(2);
         chk("ready adv", 0, ev_o.ready_adv);
         if (m == 0) begin
            chk("markers", 0, ev_o.marker);
            smp(SR - 4);
            do_ref(0);
            smp(6);
            chk("ready adv", 1, ev_o.ready_adv);
            do_ref(1);
            smp(RR - 4);
            do_ref(0);
            smp(6);
            do_ref(1);
         end else begin
            do_ref(0);
         end
         u_ext.drive(3, 1'b1);
         tick(3);
         chk("end record", m == 0, ev_o.end_record);
         u_ext.drive(3, 1'b0);
         t0 = cyc;
         u_ext.drive(2, !m[0]);
         for (int i = 0; i < 400 && paused_o !== 1'b1; i++) tick(1);
         t1 = cyc - t0;
         if (m) chk("gen pause", 1, t1 >= LAT+31-TOL && t1 <= LAT+31+TOL);
         else chk("acq pause", 1, t1 >= 1 && t1 <= DIV + 2);
         chk("data active", 0, ev_o.data_active);
         u_ext.drive(2, m[0]);
         for (int i = 0; i < 400 && paused_o !== 1'b0; i++) tick(1);
         chk("pause level", 0, paused_o);
         tick(LAT + 60);
         stop_i = 1'b1;
         tick(1);
         stop_i = 1'b0;
         tick(2);
         chk("ready start", 1, ev_o.ready_start);
      end
      tick(300);
      chk("pending notes", 0, acc_q.size() + trig_q.size());
      end_sim();
   end
endmodule
`default_nettype wire
